// ==== rtl/fqe_pkg.sv ====
// Function
// - query table signature reads P, R, I
// - optional-feature location reads 86h
// - sync read support in three locations
// - suspend-functions location reads 01h
// - block status mask location reads 00h
// - host clears status after any error
// - host suspends with B0h then 70h
// - ready bit low until suspend effective
// - suspended bit shows erase truly suspended
// - suspended erase allows other-block reads, programs
// - host resumes with D0h after program done
// - finished erase stays in status read until FFh
// - query command enters query mode
// - query bytes on low lane, upper zero
// - offset 15h points to extended table
package fqe_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 32;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_QUERY = 8'h98;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam int RDY_BIT = 7;
   localparam int ESUS_BIT = 6;
   localparam int EERR_BIT = 5;
   localparam int PERR_BIT = 4;
   localparam int PSUS_BIT = 2;
   localparam logic [7:0] QA_Q = 8'h10;
   localparam logic [7:0] QA_R = 8'h11;
   localparam logic [7:0] QA_Y = 8'h12;
   localparam logic [7:0] QA_SIG0 = 8'h35;
   localparam logic [7:0] QA_SIG1 = 8'h36;
   localparam logic [7:0] QA_SIG2 = 8'h37;
   localparam logic [7:0] QA_VMAJ = 8'h38;
   localparam logic [7:0] QA_VMIN = 8'h39;
   localparam logic [7:0] QA_OPT = 8'h3A;
   localparam logic [7:0] QA_SYNC0 = 8'h3B;
   localparam logic [7:0] QA_SYNC1 = 8'h3C;
   localparam logic [7:0] QA_SYNC2 = 8'h3D;
   localparam logic [7:0] QA_SUSFN = 8'h3E;
   localparam logic [7:0] QA_BSR = 8'h3F;
   localparam logic [7:0] Q_PTR_ADDR = 8'h15;
   localparam logic [7:0] Q_PTR_VAL = 8'h35;
   localparam logic [7:0] Q_SIG0 = 8'h50;
   localparam logic [7:0] Q_SIG1 = 8'h52;
   localparam logic [7:0] Q_SIG2 = 8'h49;
   localparam logic [7:0] Q_VER = 8'h31;
   localparam logic [7:0] Q_OPT = 8'h86;
   localparam logic [7:0] Q_SYNC0 = 8'h01;
   localparam logic [7:0] Q_ZERO = 8'h00;
   localparam logic [7:0] Q_SUSFN = 8'h01;
   localparam logic [7:0] Q_BSR = 8'h00;
   localparam logic [7:0] Q_Q = 8'h51;
   localparam logic [7:0] Q_R = 8'h52;
   localparam logic [7:0] Q_Y = 8'h59;
   localparam int ERASE_CYC = 64;
   localparam int PROG_CYC = 8;
   localparam int SUSP_CYC = 4;
   localparam int BLK_LSB = 16;
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0C;
   localparam logic [7:0] REG_CTRL = 8'h10;
   localparam logic [7:0] REG_IRQ_STAT = 8'h14;
   localparam logic [7:0] REG_IRQ_MASK = 8'h18;
   typedef enum logic [1:0] {
      FQE_MODE_ARRAY = 2'b00,
      FQE_MODE_STATUS = 2'b01,
      FQE_MODE_QUERY = 2'b10
   } fqe_mode_t;
   typedef enum logic [2:0] {
      FQE_PEC_IDLE = 3'b000,
      FQE_PEC_ERASE = 3'b001,
      FQE_PEC_SUSPENDING = 3'b010,
      FQE_PEC_SUSPENDED = 3'b011,
      FQE_PEC_PROG = 3'b100,
      FQE_PEC_PROG_SUS = 3'b101
   } fqe_pec_t;
   typedef enum logic [1:0] {
      FQE_H_IDLE = 2'b00,
      FQE_H_WR = 2'b01,
      FQE_H_RD = 2'b10,
      FQE_H_RD2 = 2'b11
   } fqe_host_t;
endpackage : fqe_pkg

// ==== rtl/fqe_bus_if.sv ====
`timescale 1ns/10ps
interface fqe_bus_if import fqe_pkg::*; ();
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] dq_wr;
   logic [DATA_W-1:0] dq_rd;
   logic dq_oe_b;
   logic we;
   logic re;
   modport dev (input addr, input dq_wr, input we, input re, output dq_rd, output dq_oe_b);
   modport host (output addr, output dq_wr, output we, output re, input dq_rd, input dq_oe_b);
endinterface : fqe_bus_if

// ==== rtl/fqe_flash_dev.sv ====
`timescale 1ns/10ps
module fqe_flash_dev import fqe_pkg::*; #(
   parameter int ERASE_CYCLES = ERASE_CYC,
   parameter int PROG_CYCLES = PROG_CYC,
   parameter int SUSP_CYCLES = SUSP_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   fqe_bus_if.dev bus,
   output logic [7:0] status_byte
);
   logic [DATA_W-1:0] mem [0:15];
   fqe_mode_t mode;
   fqe_pec_t pec;
   logic [15:0] cnt;
   logic [7:0] pend;
   logic err_e, err_p;
   logic [ADDR_W-1:0] ers_addr;
   logic [DATA_W-1:0] rd_q;
   logic oe_b_q;
   logic [7:0] cmd;
   assign cmd = bus.dq_wr[7:0];
   function automatic logic [7:0] query_byte(input logic [7:0] a);
      case (a)
         QA_Q: query_byte = Q_Q;
         QA_R: query_byte = Q_R;
         QA_Y: query_byte = Q_Y;
         Q_PTR_ADDR: query_byte = Q_PTR_VAL;
         QA_SIG0: query_byte = Q_SIG0;
         QA_SIG1: query_byte = Q_SIG1;
         QA_SIG2: query_byte = Q_SIG2;
         QA_VMAJ, QA_VMIN: query_byte = Q_VER;
         QA_OPT: query_byte = Q_OPT;
         QA_SYNC0: query_byte = Q_SYNC0;
         QA_SYNC1, QA_SYNC2: query_byte = Q_ZERO;
         QA_SUSFN: query_byte = Q_SUSFN;
         QA_BSR: query_byte = Q_BSR;
         default: query_byte = Q_ZERO;
      endcase
   endfunction : query_byte
   wire busy = (pec == FQE_PEC_ERASE) || (pec == FQE_PEC_SUSPENDING) || (pec == FQE_PEC_PROG)
      || (pec == FQE_PEC_PROG_SUS);
   // ready stays low through the suspend latency
   wire rdy = !busy;
   wire esus = (pec == FQE_PEC_SUSPENDED) || (pec == FQE_PEC_PROG_SUS);
   assign status_byte = {rdy, esus, err_e, err_p, 4'h0};
   wire same_blk = bus.addr[ADDR_W-1:BLK_LSB] == ers_addr[ADDR_W-1:BLK_LSB];
   // a program may not clobber a running erase, nor touch the block whose erase is parked
   wire prog_ok = ((pec == FQE_PEC_IDLE) || (pec == FQE_PEC_SUSPENDED)) && !err_e && !err_p
      && !(esus && same_blk);
   wire [3:0] widx = bus.addr[3:0];
   wire [DATA_W-1:0] rd_val = (mode == FQE_MODE_QUERY) ? {24'h00_0000, query_byte(bus.addr[7:0])}
      : (mode == FQE_MODE_STATUS) ? {24'h00_0000, status_byte}
      : (esus && same_blk) ? '0 : mem[widx];
   assign bus.dq_rd = rd_q;
   assign bus.dq_oe_b = oe_b_q;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_q <= '0;
         oe_b_q <= 1'b1;
      end else if (clk_en) begin
         rd_q <= rd_val;
         oe_b_q <= !bus.re;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (clk_en && bus.we && pend == CMD_PROGRAM_SETUP && prog_ok) begin
         mem[widx] <= bus.dq_wr;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode <= FQE_MODE_ARRAY;
         pec <= FQE_PEC_IDLE;
         cnt <= '0;
         pend <= '0;
         err_e <= 1'b0;
         err_p <= 1'b0;
         ers_addr <= '0;
      end else if (clk_en) begin
         if (cnt != 0) begin
            cnt <= cnt - 16'd1;
         end else begin
            case (pec)
               // ends like an unsuspended erase: status reads go on until the host asks for array
               FQE_PEC_ERASE: pec <= FQE_PEC_IDLE;
               FQE_PEC_SUSPENDING: pec <= FQE_PEC_SUSPENDED;
               FQE_PEC_PROG: pec <= FQE_PEC_IDLE;
               FQE_PEC_PROG_SUS: pec <= FQE_PEC_SUSPENDED;
               default: pec <= pec;
            endcase
         end
         if (bus.we) begin
            if (pend == CMD_ERASE_SETUP) begin
               pend <= '0;
               mode <= FQE_MODE_STATUS;
               if (cmd == CMD_CONFIRM && pec == FQE_PEC_IDLE && !err_e && !err_p) begin
                  pec <= FQE_PEC_ERASE;
                  cnt <= 16'(ERASE_CYCLES);
                  ers_addr <= bus.addr;
               end else begin
                  err_e <= 1'b1;
               end
            end else if (pend == CMD_PROGRAM_SETUP) begin
               pend <= '0;
               mode <= FQE_MODE_STATUS;
               if (!prog_ok) begin
                  err_p <= 1'b1;
               end else begin
                  pec <= (pec == FQE_PEC_SUSPENDED) ? FQE_PEC_PROG_SUS : FQE_PEC_PROG;
                  cnt <= 16'(PROG_CYCLES);
               end
            end else begin
               case (cmd)
                  CMD_READ_ARRAY: mode <= FQE_MODE_ARRAY;
                  CMD_READ_STATUS: mode <= FQE_MODE_STATUS;
                  CMD_QUERY: mode <= FQE_MODE_QUERY;
                  CMD_CLEAR_STATUS: begin
                     err_e <= 1'b0;
                     err_p <= 1'b0;
                  end
                  CMD_ERASE_SETUP, CMD_PROGRAM_SETUP: pend <= cmd;
                  CMD_SUSPEND: begin
                     mode <= FQE_MODE_STATUS;
                     // an erase finishing on this edge is reported as complete, not suspended
                     if ((pec == FQE_PEC_ERASE) && (cnt != 16'd0)) begin
                        pec <= FQE_PEC_SUSPENDING;
                        cnt <= 16'(SUSP_CYCLES);
                     end
                  end
                  CMD_CONFIRM: if (pec == FQE_PEC_SUSPENDED) begin
                     pec <= FQE_PEC_ERASE;
                     cnt <= 16'(ERASE_CYCLES);
                     mode <= FQE_MODE_STATUS;
                  end
                  default: mode <= mode;
               endcase
            end
         end
      end
   end
endmodule : fqe_flash_dev

// ==== rtl/fqe_flash_host.sv ====
`timescale 1ns/10ps
module fqe_flash_host import fqe_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   fqe_bus_if.host bus
);
   fqe_host_t st;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q, rdata_q, bus_wd;
   logic [7:0] irq_stat, irq_mask;
   logic we_q, re_q, done_q;
   logic [7:0] last_stat;
   logic stat_mode;
   wire is_cmd = avs_address == REG_CMD;
   wire is_rd = avs_address == REG_RDATA;
   wire bus_op = (avs_write && is_cmd) || (avs_read && is_rd);
   // bus ops stall the master until the link cycle completes
   assign avs_waitrequest = bus_op && !done_q;
   wire [7:0] wcode = avs_writedata[7:0];
   // status mode is inferred from this host's own command stream only
   wire to_stat = avs_writedata[8] || (wcode == CMD_READ_STATUS) || (wcode == CMD_SUSPEND)
      || (wcode == CMD_CONFIRM);
   wire to_array = !avs_writedata[8] && ((wcode == CMD_READ_ARRAY) || (wcode == CMD_QUERY));
   // array and query data must not raise status events
   wire stat_rd = (st == FQE_H_RD2) && stat_mode;
   wire [7:0] ev = {6'h00, stat_rd && bus.dq_rd[EERR_BIT],
      stat_rd && bus.dq_rd[RDY_BIT] && !last_stat[RDY_BIT]};
   assign irq = |(irq_stat & irq_mask);
   assign bus.addr = addr_q;
   assign bus.dq_wr = bus_wd;
   assign bus.we = we_q;
   assign bus.re = re_q;
   always_comb begin
      case (avs_address)
         REG_ADDR: avs_readdata = 32'(addr_q);
         REG_WDATA: avs_readdata = wdata_q;
         REG_RDATA: avs_readdata = rdata_q;
         REG_CTRL: avs_readdata = {24'h00_0000, last_stat};
         REG_IRQ_STAT: avs_readdata = {24'h00_0000, irq_stat};
         REG_IRQ_MASK: avs_readdata = {24'h00_0000, irq_mask};
         default: avs_readdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= FQE_H_IDLE;
         addr_q <= '0;
         wdata_q <= '0;
         rdata_q <= '0;
         bus_wd <= '0;
         irq_stat <= '0;
         irq_mask <= '0;
         we_q <= 1'b0;
         re_q <= 1'b0;
         done_q <= 1'b0;
         last_stat <= '0;
         stat_mode <= 1'b0;
      end else if (clk_en) begin
         done_q <= 1'b0;
         we_q <= 1'b0;
         // set beats clear on the same edge
         irq_stat <= (irq_stat & ~((avs_write && avs_address == REG_IRQ_STAT) ?
            avs_writedata[7:0] : 8'h00)) | ev;
         case (st)
            FQE_H_IDLE: begin
               if (avs_write && avs_address == REG_ADDR) addr_q <= avs_writedata[ADDR_W-1:0];
               if (avs_write && avs_address == REG_WDATA) wdata_q <= avs_writedata;
               if (avs_write && avs_address == REG_IRQ_MASK) irq_mask <= avs_writedata[7:0];
               if (avs_write && is_cmd && !done_q) begin
                  // command code sent as written: B0h then 70h etc.
                  bus_wd <= (avs_writedata[8]) ? wdata_q : {24'h00_0000, avs_writedata[7:0]};
                  stat_mode <= to_stat || (stat_mode && !to_array);
                  we_q <= 1'b1;
                  st <= FQE_H_WR;
               end else if (avs_read && is_rd && !done_q) begin
                  re_q <= 1'b1;
                  st <= FQE_H_RD;
               end
            end
            FQE_H_WR: begin
               done_q <= 1'b1;
               st <= FQE_H_IDLE;
            end
            FQE_H_RD: st <= FQE_H_RD2;
            FQE_H_RD2: begin
               rdata_q <= bus.dq_rd;
               if (stat_mode) last_stat <= bus.dq_rd[7:0];
               re_q <= 1'b0;
               done_q <= 1'b1;
               st <= FQE_H_IDLE;
            end
            default: st <= FQE_H_IDLE;
         endcase
      end
   end
endmodule : fqe_flash_host

// ==== dv/fqe_bus_properties.sv ====
`timescale 1ns/10ps
module fqe_bus_properties import fqe_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] dq_wr,
   input wire logic [DATA_W-1:0] dq_rd,
   input wire logic dq_oe_b,
   input wire logic we,
   input wire logic re,
   input wire logic [7:0] status_byte
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // query mode as seen on the wire; any other command write leaves it
   logic qmode;
   wire q_rd = qmode && re && !we;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) qmode <= 1'b0;
      else if (we) qmode <= (dq_wr[7:0] == CMD_QUERY);
   end
   property p_sig; q_rd && addr == 19'h0_0035 |=> dq_rd == 32'h0000_0050; endproperty
   a_sig: assert property (p_sig) else $error("signature P wrong");
   property p_opt; q_rd && addr == 19'h0_003A |=> dq_rd == 32'h0000_0086; endproperty
   a_opt: assert property (p_opt) else $error("option byte wrong");
   property p_sync; q_rd && addr == 19'h0_003B |=> dq_rd == 32'h0000_0001; endproperty
   a_sync: assert property (p_sync) else $error("sync read byte wrong");
   property p_susfn; q_rd && addr == 19'h0_003E |=> dq_rd == 32'h0000_0001; endproperty
   a_susfn: assert property (p_susfn) else $error("suspend functions wrong");
   property p_bsr; q_rd && addr == 19'h0_003F |=> dq_rd == 32'h0000_0000; endproperty
   a_bsr: assert property (p_bsr) else $error("block mask wrong");
   property p_ptr; q_rd && addr == 19'h0_0015 |=> dq_rd == 32'h0000_0035; endproperty
   a_ptr: assert property (p_ptr) else $error("table pointer wrong");
   property p_qry; q_rd && addr == 19'h0_0010 |=> dq_rd == 32'h0000_0051 && !dq_oe_b; endproperty
   a_qry: assert property (p_qry) else $error("query mode not entered");
   property p_upper; q_rd |=> dq_rd[31:8] == 24'h00_0000; endproperty
   a_upper: assert property (p_upper) else $error("upper query lanes not zero");
   // suspend latency is a parameter; eight cycles covers the default of four
   property p_susp;
      we && dq_wr[7:0] == CMD_SUSPEND && !status_byte[RDY_BIT] |-> ##[1:8] status_byte[RDY_BIT];
   endproperty
   a_susp: assert property (p_susp) else $error("suspend never became ready");
   property p_esus; $rose(status_byte[ESUS_BIT]) |-> status_byte[RDY_BIT]; endproperty
   a_esus: assert property (p_esus) else $error("suspended shown while busy");
   property p_resume;
      we && dq_wr[7:0] == CMD_CONFIRM && status_byte[ESUS_BIT] |-> ##[1:2] !status_byte[ESUS_BIT];
   endproperty
   a_resume: assert property (p_resume) else $error("resume left suspended");
endmodule : fqe_bus_properties

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench import fqe_pkg::*;;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   logic [7:0] status_byte;
   logic [31:0] q;
   logic [31:0] s;
   int n_errors = 0;
   int checks = 0;
   logic [18:0] q_a [11] = '{19'h10, 19'h15, 19'h35, 19'h36, 19'h37, 19'h3A, 19'h3B,
      19'h3C, 19'h3D, 19'h3E, 19'h3F};
   logic [7:0] q_d [11] = '{8'h51, 8'h35, 8'h50, 8'h52, 8'h49, 8'h86, 8'h01, 8'h00,
      8'h00, 8'h01, 8'h00};
   always #12.5 ref_clk = ~ref_clk;
   fqe_bus_if fqe_bus_if_i ();
   fqe_flash_dev fqe_flash_dev_i (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
      .bus(fqe_bus_if_i), .status_byte(status_byte));
   fqe_flash_host fqe_flash_host_i (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .bus(fqe_bus_if_i));
   fqe_bus_properties fqe_bus_properties_i (.ref_clk(ref_clk), .rst_b(rst_b),
      .addr(fqe_bus_if_i.addr), .dq_wr(fqe_bus_if_i.dq_wr), .dq_rd(fqe_bus_if_i.dq_rd),
      .dq_oe_b(fqe_bus_if_i.dq_oe_b), .we(fqe_bus_if_i.we), .re(fqe_bus_if_i.re),
      .status_byte(status_byte));
   task automatic final_report;
      if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   // waitrequest and read data are taken at the rising edge that ends the wait
   task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge ref_clk);
      end
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : av
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      av(1'b1, a, d, r);
   endtask : wr
   task automatic rd_at(input logic [18:0] a, output logic [31:0] r);
      wr(REG_ADDR, {13'h0000, a});
      av(1'b0, REG_RDATA, 32'h0000_0000, r);
   endtask : rd_at
   task automatic poll(output logic [31:0] r);
      int n;
      n = 0;
      r = 32'h0000_0000;
      wr(REG_CMD, 32'h0000_0070);
      while (r[RDY_BIT] !== 1'b1 && n < 300) begin
         av(1'b0, REG_RDATA, 32'h0000_0000, r);
         n++;
      end
   endtask : poll
   task automatic prog(input logic [18:0] a, input logic [31:0] d);
      wr(REG_ADDR, {13'h0000, a});
      wr(REG_CMD, 32'h0000_0040);
      wr(REG_WDATA, d);
      wr(REG_CMD, 32'h0000_0100);
      poll(s);
   endtask : prog
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      final_report();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(negedge ref_clk);
      `CHK("status_rst", 8'h80, status_byte)
      `CHK("irq_rst", 1'b0, irq)
      wr(REG_CMD, 32'h0000_0098);
      for (int i = 0; i < 11; i++) begin
         rd_at(q_a[i], q);
         `CHK("query", {24'h00_0000, q_d[i]}, q)
      end
      av(1'b0, 8'hFC, 32'h0000_0000, q);
      `CHK("unmapped", 32'h0000_0000, q)
      wr(REG_CMD, 32'h0000_00FF);
      prog(19'h0_0001, 32'hA5C3_0F12);
      wr(REG_CMD, 32'h0000_00FF);
      rd_at(19'h0_0001, q);
      `CHK("array", 32'hA5C3_0F12, q)
      wr(REG_ADDR, 32'h0001_0000);
      wr(REG_CMD, 32'h0000_0020);
      wr(REG_CMD, 32'h0000_00D0);
      wr(REG_CMD, 32'h0000_00B0);
      poll(s);
      `CHK("suspended", 2'b11, s[7:6])
      av(1'b0, REG_CTRL, 32'h0000_0000, q);
      `CHK("last_status", 32'h0000_00C0, q)
      wr(REG_CMD, 32'h0000_00FF);
      rd_at(19'h0_0001, q);
      `CHK("other_blk", 32'hA5C3_0F12, q)
      rd_at(19'h1_0003, q);
      `CHK("erasing_blk", 32'h0000_0000, q)
      prog(19'h0_0002, 32'h0BAD_F00D);
      wr(REG_CMD, 32'h0000_00FF);
      rd_at(19'h0_0002, q);
      `CHK("susp_prog", 32'h0BAD_F00D, q)
      wr(REG_CMD, 32'h0000_00D0);
      poll(s);
      `CHK("resumed", 2'b10, s[7:6])
      wr(REG_CMD, 32'h0000_00FF);
      rd_at(19'h0_0002, q);
      `CHK("after_resume", 32'h0BAD_F00D, q)
      wr(REG_ADDR, 32'h0001_0000);
      wr(REG_CMD, 32'h0000_0020);
      wr(REG_CMD, 32'h0000_00D0);
      poll(s);
      wr(REG_CMD, 32'h0000_00B0);
      poll(s);
      `CHK("late_susp", 2'b10, s[7:6])
      wr(REG_CMD, 32'h0000_0020);
      wr(REG_CMD, 32'h0000_00FF);
      poll(s);
      `CHK("erase_err", 1'b1, s[EERR_BIT])
      wr(REG_CMD, 32'h0000_0050);
      poll(s);
      `CHK("err_clear", 1'b0, s[EERR_BIT])
      av(1'b0, REG_IRQ_STAT, 32'h0000_0000, q);
      `CHK("irq_stat", 2'b11, q[1:0])
      `CHK("irq_masked", 1'b0, irq)
      wr(REG_IRQ_MASK, 32'h0000_0001);
      av(1'b0, REG_IRQ_MASK, 32'h0000_0000, q);
      `CHK("irq_mask", 32'h0000_0001, q)
      @(negedge ref_clk);
      `CHK("irq_on", 1'b1, irq)
      wr(REG_IRQ_STAT, 32'h0000_0001);
      @(negedge ref_clk);
      `CHK("irq_off", 1'b0, irq)
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(negedge ref_clk);
      `CHK("status_rst2", 8'h80, status_byte)
      `CHK("irq_rst2", 1'b0, irq)
      rd_at(19'h0_0001, q);
      `CHK("array_rst2", 32'hA5C3_0F12, q)
      final_report();
   end
endmodule : testbench
